// File: pkg/epp_pkg.sv
package epp_pkg;

  // Register offsets on the software bus.
  localparam logic [11:0] EPP_CTRL_OFF   = 12'h000;
  localparam logic [11:0] EPP_ADDR_OFF   = 12'h004;
  localparam logic [11:0] EPP_WDATA_OFF  = 12'h008;
  localparam logic [11:0] EPP_STATUS_OFF = 12'h00C;
  localparam logic [11:0] EPP_RDATA_OFF  = 12'h010;

  // Control register fields.
  localparam int EPP_CTRL_GO_BIT    = 0;
  localparam int EPP_CTRL_OP_LSB    = 1;
  localparam int EPP_CTRL_WIDE_BIT  = 4;
  localparam int EPP_CTRL_QUICK_BIT = 5;
  localparam int EPP_CTRL_STROBE_BIT = 6;

  // Status register fields.
  localparam int EPP_ST_BUSY_BIT = 0;
  localparam int EPP_ST_DONE_BIT = 1;
  localparam int EPP_ST_ERR_BIT  = 2;

  // Operation codes written to the control register.
  localparam logic [2:0] EPP_OP_CODE  = 3'h0;
  localparam logic [2:0] EPP_OP_VERIFY = 3'h1;
  localparam logic [2:0] EPP_OP_ENC   = 3'h2;
  localparam logic [2:0] EPP_OP_LOCK1 = 3'h3;
  localparam logic [2:0] EPP_OP_LOCK2 = 3'h4;
  localparam logic [2:0] EPP_OP_SIG   = 3'h5;

  // Timing, in ns, us or ms as each name says, and the derived cycle counts at 200 MHz.
  localparam int EPP_CLK_NS       = 5;
  localparam int EPP_OSC_NS       = 250;
  localparam int EPP_OSC_PERIODS  = 48;
  localparam int EPP_SETUP_CYC    =
    (EPP_OSC_PERIODS * EPP_OSC_NS + EPP_CLK_NS - 1) / EPP_CLK_NS;
  localparam int EPP_VPP_US       = 10;
  localparam int EPP_VPP_CYC      =
    (EPP_VPP_US * 1000 + EPP_CLK_NS - 1) / EPP_CLK_NS;
  localparam int EPP_SLOW_MS      = 50;
  localparam int EPP_SLOW_CYC     = EPP_SLOW_MS * 1000000 / EPP_CLK_NS;
  localparam int EPP_QUICK_US     = 100;
  localparam int EPP_QUICK_CYC    = EPP_QUICK_US * 1000 / EPP_CLK_NS;
  localparam int EPP_QUICK_PULSES = 25;
  localparam int EPP_OSC_DIV      = EPP_OSC_NS / EPP_CLK_NS / 2;

  // Pin bundle towards the device.
  typedef struct packed {
    logic        rst;
    logic        program_fetch_strobe;
    logic        address_latch_program_pulse;
    logic        vpp_raise;
    logic [7:0]  port1;
    logic [4:0]  port2_addr;
    logic        port2_b6;
    logic        port2_b7;
    logic        port3_b6;
    logic        port3_b7;
  } epp_pins_t;

endpackage : epp_pkg

// File: core/epp_ctrl.sv
// Added by the designer: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
// Operation
// - Keep device oscillator running at 4 MHz.
// - 4K: address on P1 and P2[3:0].
// - 4K program levels: P2.7 high, P2.6 low.
// - 4K program strobe low for 50 ms.
// - Raise programming voltage only around pulse.
// - Voltage 10 us before and after strobe.
// - Address and data stable 48 periods around.
// - Enable high 48 periods before voltage.
// - Port 0 needs pull-ups during verify.
// - Verify data valid within 48 periods.
// - Protection set holds P2.6 high.
// - 8K: address on P1 and P2[4:0].
// - 8K levels use P3.6 and P3.7.
// - Encryption table: P3.6 low, addresses 0-1FH.
// - Lock bits: P2.6 high, P3 pair selects.
// - Quick algorithm: 25 pulses of 100 us.
// - Voltage back to logic high before verify.
// - Verify whole array after programming.
// - Signature at 030H and 031H, P3 low.
module epp_ctrl
  import epp_pkg::*;
#(
  parameter int SLOW_CYC  = EPP_SLOW_CYC,
  parameter int QUICK_CYC = EPP_QUICK_CYC,
  parameter int VPP_CYC   = EPP_VPP_CYC,
  parameter int SETUP_CYC = EPP_SETUP_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             osc_out,
  output epp_pins_t        pins,
  input  wire logic [7:0]  port0_in,
  output logic      [7:0]  port0_out,
  output logic      [7:0]  port0_oe,
  output logic             port0_pullup_en
);

  typedef enum logic [6:0] {
    S_IDLE  = 7'b0000001,
    S_SETUP = 7'b0000010,
    S_VPPON = 7'b0000100,
    S_PULSE = 7'b0001000,
    S_VPPOF = 7'b0010000,
    S_HOLD  = 7'b0100000,
    S_READ  = 7'b1000000
  } epp_state_t;

  epp_state_t  st_q, st_d;
  logic [31:0] cnt_q, cnt_d;
  logic [4:0]  pulses_q, pulses_d;
  logic [2:0]  op_q, op_d;
  logic        wide_q, wide_d;
  logic        quick_q, quick_d;
  logic        strobe_q, strobe_d;
  logic [12:0] addr_q, addr_d;
  logic [7:0]  wdata_q, wdata_d;
  logic [7:0]  rdata_q, rdata_d;
  logic        done_q, done_d;
  logic        err_q, err_d;
  logic [5:0]  div_q, div_d;
  logic        osc_q, osc_d;
  logic        wr_en;
  logic        busy;
  logic        is_program_strobe;
  logic        op_ok;

  // Software writes and reads complete in the access phase with no wait.
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign wr_en   = psel && penable && pwrite;
  assign busy    = (st_q != S_IDLE);
  assign is_program_strobe = (op_q != EPP_OP_VERIFY) && (op_q != EPP_OP_SIG);
  // Encryption table only exists in the wide part, with 32 entries.
  assign op_ok = (op_q <= EPP_OP_SIG) &&
                 !((op_q == EPP_OP_ENC) && (!wide_q ||
                   addr_q[12:5] != 8'h00)) &&
                 !((op_q >= EPP_OP_ENC) && !wide_q &&
                   op_q != EPP_OP_LOCK1);

  // Read mux for the software bus.
  always_comb begin
    prdata = 32'h0000_0000;
    unique case (paddr)
      EPP_CTRL_OFF:   prdata = {25'h0, strobe_q, quick_q, wide_q, op_q, 1'b0};
      EPP_ADDR_OFF:   prdata = {19'h0, addr_q};
      EPP_WDATA_OFF:  prdata = {24'h0, wdata_q};
      EPP_STATUS_OFF: prdata = {29'h0, err_q, done_q, busy};
      EPP_RDATA_OFF:  prdata = {24'h0, rdata_q};
      default:        prdata = 32'h0000_0000;
    endcase
  end

  // Free-running device oscillator, 4 MHz from the 200 MHz clock.
  always_comb begin
    div_d = div_q + 6'h01;
    osc_d = osc_q;
    if (div_q == 6'(EPP_OSC_DIV - 1)) begin
      div_d = 6'h00;
      osc_d = !osc_q;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      div_q <= 6'h00;
      osc_q <= 1'b0;
    end else begin
      div_q <= div_d;
      osc_q <= osc_d;
    end
  end

  assign osc_out = osc_q;

  // Sequencer for program, lock and verify cycles.
  always_comb begin
    st_d     = st_q;
    cnt_d    = cnt_q;
    pulses_d = pulses_q;
    op_d     = op_q;
    wide_d   = wide_q;
    quick_d  = quick_q;
    strobe_d = strobe_q;
    addr_d   = addr_q;
    wdata_d  = wdata_q;
    rdata_d  = rdata_q;
    done_d   = done_q;
    err_d    = err_q;
    if (wr_en && !busy) begin
      if (paddr == EPP_ADDR_OFF) addr_d = pwdata[12:0];
      if (paddr == EPP_WDATA_OFF) wdata_d = pwdata[7:0];
    end
    if (wr_en && paddr == EPP_STATUS_OFF) begin
      done_d = done_q && !pwdata[EPP_ST_DONE_BIT];
      err_d  = err_q && !pwdata[EPP_ST_ERR_BIT];
    end
    unique case (st_q)
      S_IDLE: begin
        if (wr_en && paddr == EPP_CTRL_OFF && pwdata[EPP_CTRL_GO_BIT]) begin
          op_d     = pwdata[EPP_CTRL_OP_LSB +: 3];
          wide_d   = pwdata[EPP_CTRL_WIDE_BIT];
          quick_d  = pwdata[EPP_CTRL_QUICK_BIT];
          strobe_d = pwdata[EPP_CTRL_STROBE_BIT];
          cnt_d    = 32'h0000_0000;
          done_d   = 1'b0;
          st_d     = S_SETUP;
        end
      end
      S_SETUP: begin
        if (!op_ok) begin
          err_d = 1'b1;
          done_d = 1'b1;
          st_d = S_IDLE;
        end else if (cnt_q >= 32'(SETUP_CYC)) begin
          cnt_d = 32'h0000_0000;
          pulses_d = 5'h00;
          st_d = is_program_strobe ? S_VPPON : S_READ;
        end else begin
          cnt_d = cnt_q + 32'h0000_0001;
        end
      end
      S_VPPON: begin
        cnt_d = cnt_q + 32'h0000_0001;
        if (cnt_q >= 32'(VPP_CYC)) begin
          cnt_d = 32'h0000_0000;
          st_d = S_PULSE;
        end
      end
      S_PULSE: begin
        cnt_d = cnt_q + 32'h0000_0001;
        if (cnt_q >= 32'(quick_q ? QUICK_CYC : SLOW_CYC) - 1) begin
          cnt_d = 32'h0000_0000;
          pulses_d = pulses_q + 5'h01;
          st_d = S_VPPOF;
        end
      end
      S_VPPOF: begin
        cnt_d = cnt_q + 32'h0000_0001;
        if (cnt_q >= 32'(VPP_CYC)) begin
          cnt_d = 32'h0000_0000;
          // Each repeat goes back through the voltage setup time.
          if (quick_q && pulses_q < 5'(EPP_QUICK_PULSES))
            st_d = S_VPPON;
          else
            st_d = S_HOLD;
        end
      end
      S_HOLD: begin
        cnt_d = cnt_q + 32'h0000_0001;
        if (cnt_q >= 32'(SETUP_CYC)) begin
          done_d = 1'b1;
          st_d = S_IDLE;
        end
      end
      // Any address may be read back, so software can sweep the array.
      S_READ: begin
        cnt_d = cnt_q + 32'h0000_0001;
        if (cnt_q >= 32'(SETUP_CYC)) begin
          rdata_d = port0_in;
          done_d = 1'b1;
          st_d = S_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q     <= S_IDLE;
      cnt_q    <= 32'h0000_0000;
      pulses_q <= 5'h00;
      op_q     <= EPP_OP_VERIFY;
      wide_q   <= 1'b0;
      quick_q  <= 1'b0;
      strobe_q <= 1'b0;
      addr_q   <= 13'h0000;
      wdata_q  <= 8'h00;
      rdata_q  <= 8'h00;
      done_q   <= 1'b0;
      err_q    <= 1'b0;
    end else begin
      st_q     <= st_d;
      cnt_q    <= cnt_d;
      pulses_q <= pulses_d;
      op_q     <= op_d;
      wide_q   <= wide_d;
      quick_q  <= quick_d;
      strobe_q <= strobe_d;
      addr_q   <= addr_d;
      wdata_q  <= wdata_d;
      rdata_q  <= rdata_d;
      done_q   <= done_d;
      err_q    <= err_d;
    end
  end

  // Mode pins follow the latched operation while a cycle runs.
  always_comb begin
    pins = '0;
    pins.address_latch_program_pulse = 1'b1;
    pins.port3_b6 = 1'b1;
    pins.port3_b7 = 1'b1;
    if (busy) begin
      pins.rst = 1'b1;
      pins.program_fetch_strobe = 1'b0;
      pins.port1 = addr_q[7:0];
      pins.port2_addr = wide_q ? addr_q[12:8] :
                        {1'b0, addr_q[11:8]};
      pins.port2_b7 = is_program_strobe;
      pins.port2_b6 = (op_q == EPP_OP_LOCK1) ||
                      (op_q == EPP_OP_LOCK2);
      if (is_program_strobe && st_q == S_READ) pins.port2_b7 = 1'b1;
      if (!is_program_strobe && strobe_q) pins.port2_b7 = (st_q != S_READ);
      pins.port3_b6 = (op_q == EPP_OP_CODE) ||
                      (op_q == EPP_OP_VERIFY) ||
                      (op_q == EPP_OP_LOCK1);
      pins.port3_b7 = (op_q != EPP_OP_LOCK2) &&
                      (op_q != EPP_OP_SIG);
      pins.vpp_raise = (st_q == S_VPPON) || (st_q == S_PULSE) ||
                       (st_q == S_VPPOF && cnt_q < 32'(VPP_CYC));
      pins.address_latch_program_pulse = (st_q != S_PULSE);
    end
  end

  // Data byte on port 0 while programming; released for reads.
  always_comb begin
    port0_out = wdata_q;
    port0_oe  = (busy && st_q != S_READ && is_program_strobe) ? 8'hFF : 8'h00;
    port0_pullup_en = 1'b1;
  end

  property p_pulse_len;
    @(posedge clk) disable iff (!rst_b)
    $fell(pins.address_latch_program_pulse) |->
      !pins.address_latch_program_pulse [*8];
  endproperty
  a_pulse_len: assert property (p_pulse_len)
    else $error("Program strobe too short.");

  property p_vpp_cover;
    @(posedge clk) disable iff (!rst_b)
    !pins.address_latch_program_pulse |-> pins.vpp_raise;
  endproperty
  a_vpp_cover: assert property (p_vpp_cover)
    else $error("Strobe low without programming voltage.");

  property p_vpp_enable;
    @(posedge clk) disable iff (!rst_b)
    pins.vpp_raise |-> pins.port2_b7 && pins.rst;
  endproperty
  a_vpp_enable: assert property (p_vpp_enable)
    else $error("Voltage raised without enable.");

  property p_read_novpp;
    @(posedge clk) disable iff (!rst_b)
    st_q == S_READ |-> !pins.vpp_raise && port0_oe == 8'h00;
  endproperty
  a_read_novpp: assert property (p_read_novpp)
    else $error("Verify with voltage raised or port driven.");

  property p_addr_stable;
    @(posedge clk) disable iff (!rst_b)
    busy && $past(busy) |-> $stable(pins.port1) && $stable(port0_out);
  endproperty
  a_addr_stable: assert property (p_addr_stable)
    else $error("Address or data changed mid cycle.");

  property p_reset_high;
    @(posedge clk) disable iff (!rst_b)
    busy |-> pins.rst && !pins.program_fetch_strobe;
  endproperty
  a_reset_high: assert property (p_reset_high)
    else $error("Mode pins wrong during cycle.");

  property p_lock_pins;
    @(posedge clk) disable iff (!rst_b)
    busy && op_q == EPP_OP_LOCK2 |-> pins.port2_b6 &&
      !pins.port3_b6 && !pins.port3_b7;
  endproperty
  a_lock_pins: assert property (p_lock_pins)
    else $error("Lock two pin levels wrong.");

  property p_bad_op;
    @(posedge clk) disable iff (!rst_b)
    st_q == S_SETUP && !op_ok |=> st_q == S_IDLE && err_q;
  endproperty
  a_bad_op: assert property (p_bad_op)
    else $error("Undefined mode not refused.");

  property p_vpp_setup;
    @(posedge clk) disable iff (!rst_b)
    $fell(pins.address_latch_program_pulse) |->
      $past(st_q) == S_VPPON;
  endproperty
  a_vpp_setup: assert property (p_vpp_setup)
    else $error("Strobe fell without voltage setup time.");

  property p_port0_release;
    @(posedge clk) disable iff (!rst_b)
    busy && !is_program_strobe |-> port0_oe == 8'h00;
  endproperty
  a_port0_release: assert property (p_port0_release)
    else $error("Port 0 driven during a read cycle.");

  property p_verify_levels;
    @(posedge clk) disable iff (!rst_b)
    st_q == S_READ |-> !pins.port2_b7 && !pins.port2_b6 &&
      pins.address_latch_program_pulse;
  endproperty
  a_verify_levels: assert property (p_verify_levels)
    else $error("Verify levels wrong during read.");

endmodule : epp_ctrl

// File: tb/epp_dev_model.sv
`timescale 1ns/1ps
// Behavioural model of the code memory that the controller programs.
module epp_dev_model
  import epp_pkg::*;
#(
  parameter logic [7:0] SIG_MAKER = 8'hA5, // Arbitrary identity value.
  parameter logic [7:0] SIG_PART  = 8'h3C  // Arbitrary identity value.
) (
  input  wire logic       osc,
  input  wire epp_pins_t  pins,
  input  wire logic [7:0] port0,
  output logic      [7:0] pull_low_n
);
  logic [7:0]  mem [0:8191];
  logic [7:0]  enc [0:31];
  logic        lock_bit_one;
  logic        lock_bit_two;
  logic        osc_alive;
  logic        sel;
  logic        rd;
  logic [12:0] a;
  logic [7:0]  dat;

  // Everything starts erased and unlocked.
  initial begin
    for (int i = 0; i < 8192; i++) mem[i] = 8'hFF;
    for (int i = 0; i < 32; i++) enc[i] = 8'hFF;
    lock_bit_one = 1'b0;
    lock_bit_two = 1'b0;
    osc_alive = 1'b0;
  end

  // Programming needs a running oscillator; reads do not check it.
  always @(posedge osc) osc_alive <= 1'b1;

  assign a   = {pins.port2_addr, pins.port1};
  assign sel = pins.rst & ~pins.program_fetch_strobe;

  // A byte or a lock bit is burnt at the end of each pulse, bytes only while lock bit one is clear; other pin sets are ignored.
  always @(posedge pins.address_latch_program_pulse) begin
    if (sel && pins.vpp_raise && pins.port2_b7 && osc_alive) begin
      if (!pins.port2_b6 && pins.port3_b6 && pins.port3_b7) begin
        if (!lock_bit_one) mem[a] <= mem[a] & port0;
      end else if (!pins.port2_b6 && !pins.port3_b6 && pins.port3_b7) begin
        if (!lock_bit_one && a < 13'h0020)
          enc[a[4:0]] <= enc[a[4:0]] & port0;
      end else if (pins.port2_b6 && pins.port3_b6 && pins.port3_b7) begin
        lock_bit_one <= 1'b1;
      end else if (pins.port2_b6 && !pins.port3_b6 && !pins.port3_b7) begin
        lock_bit_two <= 1'b1;
      end
    end
  end

  // Verify pulls low only; lock bits themselves are never shown.
  always_comb begin
    rd  = sel && !pins.vpp_raise && pins.address_latch_program_pulse &&
          !pins.port2_b7 && !pins.port2_b6 &&
          (pins.port3_b6 == pins.port3_b7);
    dat = 8'hFF;
    if (pins.port3_b6) begin
      if (!(lock_bit_one && lock_bit_two))
        dat = ~(mem[a] ^ enc[a[4:0]]);
    end else if (a == 13'h0030) begin
      dat = SIG_MAKER;
    end else if (a == 13'h0031) begin
      dat = SIG_PART;
    end
    pull_low_n = rd ? dat : 8'hFF;
  end
endmodule : epp_dev_model

// File: tb/tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
  $display("mismatch %s exp %h got %h", nm, e, g); end end
module tb_top
  import epp_pkg::*;
;
  localparam int SLOW = 40;
  localparam int QUICK = 20;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        osc_out;
  epp_pins_t   pins;
  logic [7:0]  port0;
  logic [7:0]  port0_out;
  logic [7:0]  port0_oe;
  logic [7:0]  pull_low_n;
  logic        port0_pullup_en;
  int          bad_count = 0;
  int          n_tests = 0;
  int          cyc = 0;
  int          pulses = 0;
  int          lw = 0;
  int          last_w = 0;
  int          vbad = 0;
  logic [7:0]  r;
  logic [31:0] v;
  logic        osc_prev = 1'b0;
  int          ocnt = 0;
  int          operiod = 0;

  always #2.5 clk = ~clk;

  // Open-drain port 0 with pull-ups: any party pulling low wins.
  assign port0 = pull_low_n & (port0_out | ~port0_oe);

  epp_ctrl #(.SLOW_CYC(SLOW), .QUICK_CYC(QUICK), .VPP_CYC(10),
    .SETUP_CYC(4)) dut (.clk(clk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .osc_out(osc_out),
    .pins(pins), .port0_in(port0), .port0_out(port0_out),
    .port0_oe(port0_oe), .port0_pullup_en(port0_pullup_en));

  epp_dev_model u_dev (.osc(osc_out), .pins(pins), .port0(port0),
    .pull_low_n(pull_low_n));

  // Watches pulse count, pulse width and voltage sequencing.
  always @(posedge clk) begin
    if (pins.address_latch_program_pulse === 1'b0) begin
      lw <= lw + 1;
      if (pins.vpp_raise !== 1'b1) vbad <= vbad + 1;
    end else if (lw != 0) begin
      last_w <= lw;
      lw <= 0;
      pulses <= pulses + 1;
    end
    if (pins.vpp_raise === 1'b1 && pins.port2_b7 !== 1'b1) vbad <= vbad + 1;
  end

  // Measures the device oscillator period in clock cycles.
  always @(posedge clk) begin
    osc_prev <= osc_out;
    ocnt <= ocnt + 1;
    if (osc_out === 1'b1 && osc_prev === 1'b0) begin
      operiod <= ocnt;
      ocnt <= 1;
    end
  end

  // Cuts a hang short.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      bad_count++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_of_test

  // One APB transfer, started just after a rising edge.
  task automatic apb(input logic wr, input logic [11:0] ad,
                     input logic [31:0] wd, output logic [31:0] rd);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  // Runs one operation, checks its error flag and fetches read data.
  task automatic op(input logic [2:0] code, input logic wide, quick, stb,
                    input logic [12:0] ad, input logic [7:0] d,
                    input logic eerr, output logic [7:0] rdat);
    logic [31:0] s;
    int i;
    apb(1'b1, EPP_ADDR_OFF, {19'h0, ad}, s);
    apb(1'b1, EPP_WDATA_OFF, {24'h0, d}, s);
    pulses = 0;
    apb(1'b1, EPP_CTRL_OFF, {25'h0, stb, quick, wide, code, 1'b1}, s);
    i = 0;
    do begin
      apb(1'b0, EPP_STATUS_OFF, 32'h0, s);
      i++;
    end while (s[EPP_ST_DONE_BIT] !== 1'b1 && s[EPP_ST_ERR_BIT] !== 1'b1
               && i < 3000);
    `CHK("done", 1'b1, s[EPP_ST_DONE_BIT])
    `CHK("err", eerr, s[EPP_ST_ERR_BIT])
    apb(1'b1, EPP_STATUS_OFF, 32'h6, s);
    apb(1'b0, EPP_RDATA_OFF, 32'h0, s);
    rdat = s[7:0];
  endtask : op

  // Main sequence.
  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    op(EPP_OP_VERIFY, 1'b1, 1'b0, 1'b1, 13'h0123, 8'h00, 1'b0, r);
    `CHK("erased", 8'hFF, r)
    `CHK("pullup", 1'b1, port0_pullup_en)
    op(EPP_OP_CODE, 1'b1, 1'b1, 1'b0, 13'h1ABC, 8'h5A, 1'b0, r);
    `CHK("qpulses", 25, pulses)
    `CHK("qwidth", QUICK, last_w)
    op(EPP_OP_VERIFY, 1'b1, 1'b0, 1'b1, 13'h1ABC, 8'h00, 1'b0, r);
    `CHK("wide", 8'h5A, r)
    op(EPP_OP_CODE, 1'b0, 1'b0, 1'b0, 13'h0345, 8'h3C, 1'b0, r);
    `CHK("spulses", 1, pulses)
    `CHK("swidth", SLOW, last_w)
    op(EPP_OP_VERIFY, 1'b0, 1'b0, 1'b0, 13'h0345, 8'h00, 1'b0, r);
    `CHK("narrow", 8'h3C, r)
    op(EPP_OP_ENC, 1'b1, 1'b1, 1'b0, 13'h001C, 8'h0F, 1'b0, r);
    op(EPP_OP_VERIFY, 1'b1, 1'b0, 1'b0, 13'h1ABC, 8'h00, 1'b0, r);
    `CHK("xnor", 8'hAA, r)
    op(EPP_OP_ENC, 1'b1, 1'b1, 1'b0, 13'h0020, 8'h00, 1'b1, r);
    `CHK("encrefuse", 0, pulses)
    op(EPP_OP_ENC, 1'b0, 1'b1, 1'b0, 13'h0001, 8'h00, 1'b1, r);
    op(EPP_OP_SIG, 1'b1, 1'b0, 1'b0, 13'h0030, 8'h00, 1'b0, r);
    `CHK("sig0", 8'hA5, r)
    op(EPP_OP_SIG, 1'b1, 1'b0, 1'b0, 13'h0031, 8'h00, 1'b0, r);
    `CHK("sig1", 8'h3C, r)
    op(EPP_OP_LOCK1, 1'b0, 1'b0, 1'b0, 13'h0000, 8'h00, 1'b0, r);
    `CHK("secpulses", 1, pulses)
    op(EPP_OP_CODE, 1'b1, 1'b1, 1'b0, 13'h0002, 8'h00, 1'b0, r);
    op(EPP_OP_VERIFY, 1'b1, 1'b0, 1'b0, 13'h0002, 8'h00, 1'b0, r);
    `CHK("lock1", 8'hFF, r)
    op(EPP_OP_LOCK2, 1'b1, 1'b1, 1'b0, 13'h0000, 8'h00, 1'b0, r);
    op(EPP_OP_VERIFY, 1'b1, 1'b0, 1'b0, 13'h1ABC, 8'h00, 1'b0, r);
    `CHK("lock2", 8'hFF, r)
    apb(1'b0, 12'h0FC, 32'h0, v);
    `CHK("unmapped", 32'h0, v)
    `CHK("slverr", 1'b0, pslverr)
    `CHK("oscper", EPP_OSC_NS / EPP_CLK_NS, operiod)
    `CHK("vppseq", 0, vbad)
    end_of_test();
  end
endmodule : tb_top
